/* dbgmb_pkg.sv */
// Purpose: constants for the debug mailbox block
// Assumes: single core clock, serial debug link sampled by that clock
// Notes: scan chain select and register addresses of the serial side
package dbgmb_pkg;
  localparam int unsigned DBGMB_W = 32;
  // version code is arbitrary
  localparam logic [3:0] DBGMB_VERSION = 4'hA;
  localparam int unsigned DBGMB_VER_MSB = 31;
  localparam int unsigned DBGMB_VER_LSB = 28;
  localparam int unsigned DBGMB_TXF_BIT = 1;
  localparam int unsigned DBGMB_RXF_BIT = 0;
  // coprocessor decode
  localparam logic [3:0] DBGMB_CP_NUM = 4'hE;
  localparam logic [2:0] DBGMB_CP_OPC = 3'h0;
  localparam logic [3:0] DBGMB_CRN_CTRL = 4'h0;
  localparam logic [3:0] DBGMB_CRN_DATA = 4'h1;
  localparam logic [3:0] DBGMB_CRM = 4'h0;
  // serial side
  localparam logic [3:0] DBGMB_CHAIN = 4'h2;
  localparam logic [4:0] DBGMB_ADDR_CTRL = 5'h04;
  localparam logic [4:0] DBGMB_ADDR_DATA = 5'h05;
  // frame: 32 data, 5 address, 1 write flag, shifted lsb first
  localparam int unsigned DBGMB_FRAME = 38;
  localparam int unsigned DBGMB_ADDR_LSB = 32;
  localparam int unsigned DBGMB_WR_BIT = 37;
endpackage

/* dbgmb_top.sv */
// Purpose: debug mailbox between the core and an external debugger
// Assumes: link clock, data, select and update come from the debugger pins
// Notes: the link is sampled by i_clk, so its clock must run below i_clk / 4
//
// How it works
// - state output latches the compressed state on halt entry
// - enable low ignores breakpoint and request
// - enable low holds acknowledge low
// - enable low passes interrupts unmasked
// - enable low freezes the link shift register, tdo and update decode
// - receive, transmit, control registers, 32 bits
// - debugger uses chain 2, core coprocessor
// - control top nibble is version, bits 27:2 reserved
// - control bit 1 shows transmit full
// - control bit 0 shows receive full
// - debugger control write with bit 0 low clears control bit 0
// - core data read clears receive full
// - coprocessor decode of control and data
// - core transmit write sets transmit full
// - debugger transmit read clears transmit full
// - debugger sees synchronized full flags
// - debugger receive write sets receive full
// - receive interrupt while a word waits
// - transmit interrupt while transmit empty
`timescale 1ns/1ns
module dbgmb_top
  import dbgmb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_debug_feature_enable,
  input wire logic i_external_breakpoint_in,
  input wire logic i_debug_request_in,
  input wire logic i_core_halted,
  input wire logic i_core_compressed_state,
  input wire logic i_normal_interrupt_in,
  input wire logic i_fast_interrupt_in,
  input wire logic i_cp_valid,
  input wire logic i_cp_read,
  input wire logic [3:0] i_cp_num,
  input wire logic [2:0] i_cp_opc,
  input wire logic [3:0] i_cp_crn,
  input wire logic [3:0] i_cp_crm,
  input wire logic [dbgmb_pkg::DBGMB_W-1:0] i_cp_wdata,
  input wire logic i_link_clk,
  input wire logic i_link_tdi,
  input wire logic i_link_shift,
  input wire logic i_link_update,
  input wire logic [3:0] i_link_chain,
  output logic o_link_tdo,
  output logic [dbgmb_pkg::DBGMB_W-1:0] o_cp_rdata,
  output logic o_cp_rvalid,
  output logic o_debug_acknowledge_out,
  output logic o_debug_halt_req,
  output logic o_core_irq,
  output logic o_core_fiq,
  output logic o_mailbox_rx_full_irq,
  output logic o_mailbox_tx_empty_irq,
  output logic o_state_compressed
);
  import dbgmb_pkg::*;

  logic [DBGMB_W-1:0] rx_data;
  logic [DBGMB_W-1:0] tx_data;
  logic rx_full;
  logic tx_full;
  logic en_s1, en_s2;
  logic [3:0] lk_s1, lk_s2;
  logic [3:0] chain_s1, chain_s2;
  logic [1:0] req_s1, req_s2;
  logic lclk_d;
  logic [1:0] flag_s1, flag_s2;
  logic [DBGMB_FRAME-1:0] sreg;
  logic halted_d;

  // the pins all come from outside the clock domain: two flops each
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      lk_s1 <= 4'h0;
      lk_s2 <= 4'h0;
      chain_s1 <= 4'h0;
      chain_s2 <= 4'h0;
      req_s1 <= 2'h0;
      req_s2 <= 2'h0;
    end else begin
      en_s1 <= i_debug_feature_enable;
      en_s2 <= en_s1;
      lk_s1 <= {i_link_update, i_link_shift, i_link_tdi, i_link_clk};
      lk_s2 <= lk_s1;
      // the chain number is compared only after both flops, never on the raw pins
      chain_s1 <= i_link_chain;
      chain_s2 <= chain_s1;
      req_s1 <= {i_external_breakpoint_in, i_debug_request_in};
      req_s2 <= req_s1;
    end
  end

  // synced link pins; the chain select is decoded from the synced chain number
  wire chain_sel = (chain_s2 == DBGMB_CHAIN);
  wire lclk_rise = lk_s2[0] & ~lclk_d;
  wire lk_tdi = lk_s2[1];
  wire lk_shift = lk_s2[2];
  wire lk_update = lk_s2[3];
  logic upd_d;
  wire upd_pulse = lk_update & ~upd_d & chain_sel & en_s2;
  wire [4:0] s_addr = sreg[DBGMB_ADDR_LSB +: 5];
  wire s_wr = sreg[DBGMB_WR_BIT];
  wire dbg_wr_rx = upd_pulse & s_wr & (s_addr == DBGMB_ADDR_DATA);
  wire dbg_wr_ctrl = upd_pulse & s_wr & (s_addr == DBGMB_ADDR_CTRL);
  wire dbg_rd_tx = upd_pulse & ~s_wr & (s_addr == DBGMB_ADDR_DATA);

  wire cp_hit = i_cp_valid & (i_cp_num == DBGMB_CP_NUM) & (i_cp_opc == DBGMB_CP_OPC)
    & (i_cp_crm == DBGMB_CRM);
  wire cp_rd_ctrl = cp_hit & i_cp_read & (i_cp_crn == DBGMB_CRN_CTRL);
  wire cp_rd_data = cp_hit & i_cp_read & (i_cp_crn == DBGMB_CRN_DATA);
  wire cp_wr_data = cp_hit & ~i_cp_read & (i_cp_crn == DBGMB_CRN_DATA);

  // control word: version, zero reserved bits, full flags
  wire [DBGMB_W-1:0] ctrl_word = {DBGMB_VERSION, 26'h0, tx_full, rx_full};

  // flags synchronized towards the debugger view
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_s1 <= 2'h0;
      flag_s2 <= 2'h0;
    end else begin
      flag_s1 <= {tx_full, rx_full};
      flag_s2 <= flag_s1;
    end
  end

  // link edge detect and capture/shift register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lclk_d <= 1'b0;
      upd_d <= 1'b0;
      sreg <= '0;
      o_link_tdo <= 1'b0;
    end else begin
      lclk_d <= lk_s2[0];
      upd_d <= lk_update;
      if (lclk_rise && chain_sel && en_s2) begin
        if (lk_shift) begin
          o_link_tdo <= sreg[0];
          sreg <= {lk_tdi, sreg[DBGMB_FRAME-1:1]};
        end else begin
          // capture: data picks tx word, control picks synced flags
          if (s_addr == DBGMB_ADDR_CTRL) begin
            sreg[DBGMB_W-1:0] <= {DBGMB_VERSION, 26'h0, flag_s2};
          end else begin
            sreg[DBGMB_W-1:0] <= tx_data;
          end
        end
      end
    end
  end

  // receive register and its full flag; a set beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_data <= '0;
      rx_full <= 1'b0;
    end else begin
      if (dbg_wr_rx) begin
        rx_data <= sreg[DBGMB_W-1:0];
        rx_full <= 1'b1;
      end else if (cp_rd_data || (dbg_wr_ctrl && !sreg[DBGMB_RXF_BIT])) begin
        rx_full <= 1'b0;
      end
    end
  end

  // transmit register and its full flag
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_data <= '0;
      tx_full <= 1'b0;
    end else begin
      if (cp_wr_data) begin
        tx_data <= i_cp_wdata;
        tx_full <= 1'b1;
      end else if (dbg_rd_tx) begin
        tx_full <= 1'b0;
      end
    end
  end

  // coprocessor read answer, one cycle after the request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cp_rdata <= '0;
      o_cp_rvalid <= 1'b0;
    end else begin
      o_cp_rvalid <= cp_rd_ctrl | cp_rd_data;
      if (cp_rd_ctrl) begin
        o_cp_rdata <= ctrl_word;
      end else if (cp_rd_data) begin
        o_cp_rdata <= rx_data;
      end
    end
  end

  // debug control: requests gated by enable, state bit latched on halt entry
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      halted_d <= 1'b0;
      o_state_compressed <= 1'b0;
      o_debug_halt_req <= 1'b0;
      o_debug_acknowledge_out <= 1'b0;
    end else begin
      halted_d <= i_core_halted;
      o_debug_halt_req <= en_s2 & (req_s2[0] | req_s2[1]);
      o_debug_acknowledge_out <= en_s2 & i_core_halted;
      if (i_core_halted && !halted_d) begin
        o_state_compressed <= i_core_compressed_state;
      end
    end
  end

  // interrupts: irq and fiq masked only while debug is enabled and the core is halted; mailbox interrupts never masked
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_irq <= 1'b0;
      o_core_fiq <= 1'b0;
      o_mailbox_rx_full_irq <= 1'b0;
      o_mailbox_tx_empty_irq <= 1'b0;
    end else begin
      o_core_irq <= i_normal_interrupt_in & ~(en_s2 & i_core_halted);
      o_core_fiq <= i_fast_interrupt_in & ~(en_s2 & i_core_halted);
      o_mailbox_rx_full_irq <= rx_full;
      o_mailbox_tx_empty_irq <= ~tx_full;
    end
  end

  AST_ACK_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !en_s2 |=> !o_debug_acknowledge_out) else $error("ack high while disabled");
  AST_REQ_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !en_s2 |=> !o_debug_halt_req) else $error("request passed while disabled");
  AST_IRQ_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !en_s2 |=> o_core_irq == $past(i_normal_interrupt_in)) else $error("irq masked while disabled");
  AST_TX_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cp_wr_data |=> tx_full ##1 !o_mailbox_tx_empty_irq) else $error("tx full not set");
  AST_TX_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    dbg_rd_tx && !cp_wr_data |=> !tx_full) else $error("tx full not cleared");
  AST_RX_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    dbg_wr_rx |=> rx_full ##1 o_mailbox_rx_full_irq) else $error("rx full not set");
  AST_RX_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cp_rd_data && !dbg_wr_rx |=> !rx_full) else $error("rx full not cleared");
  AST_CTRL_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cp_rd_ctrl |=> o_cp_rvalid && o_cp_rdata[31:28] == DBGMB_VERSION && o_cp_rdata[27:2] == 26'h0
      && o_cp_rdata[1:0] == $past({tx_full, rx_full})) else $error("bad control read");
  AST_SYNC: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flag_s2 == $past({tx_full, rx_full}, 2)) else $error("flag sync delay wrong");
  AST_STATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_core_halted && !halted_d |=> o_state_compressed == $past(i_core_compressed_state))
    else $error("state bit not captured");

  // enable gating: what must happen once debug is on, and fiq passing while it is off
  AST_ACK_ON: assert property (@(posedge i_clk) disable iff (!i_rstn)
    en_s2 && i_core_halted |=> o_debug_acknowledge_out) else $error("ack missing while halted");
  AST_HALT_ON: assert property (@(posedge i_clk) disable iff (!i_rstn)
    en_s2 && (req_s2 != 2'h0) |=> o_debug_halt_req) else $error("request not passed");
  AST_IRQ_MASK: assert property (@(posedge i_clk) disable iff (!i_rstn)
    en_s2 && i_core_halted |=> !o_core_irq && !o_core_fiq) else $error("irq not masked in debug");
  AST_FIQ_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !en_s2 |=> o_core_fiq == $past(i_fast_interrupt_in)) else $error("fiq masked while disabled");

  // low power: the link shift register and tdo must not move while debug is off
  AST_LOWPWR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !en_s2 |=> $stable(sreg) && $stable(o_link_tdo)) else $error("link moved while disabled");

  // serial frame shifting and the data handed out on tdo
  AST_SHIFT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    lclk_rise && chain_sel && en_s2 && lk_shift |=> sreg[DBGMB_FRAME-1] == $past(lk_tdi))
    else $error("shift did not take tdi");
  AST_TDO: assert property (@(posedge i_clk) disable iff (!i_rstn)
    lclk_rise && chain_sel && en_s2 && lk_shift |=> o_link_tdo == $past(sreg[0]))
    else $error("tdo not lsb first");

  // mailbox words and flags
  AST_RX_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    dbg_wr_rx |=> rx_data == $past(sreg[DBGMB_W-1:0])) else $error("rx word not loaded");
  AST_TX_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cp_wr_data |=> tx_data == $past(i_cp_wdata)) else $error("tx word not loaded");
  AST_DBG_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    dbg_wr_ctrl && !sreg[DBGMB_RXF_BIT] && !dbg_wr_rx |=> !rx_full) else $error("debugger clear lost");
  AST_DATA_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cp_rd_data |=> o_cp_rvalid && o_cp_rdata == $past(rx_data)) else $error("bad data read");
  AST_RVALID: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(cp_rd_ctrl || cp_rd_data) |=> !o_cp_rvalid) else $error("stray read answer");

  // interrupt outputs follow the flags one cycle later
  AST_RX_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> o_mailbox_rx_full_irq == $past(rx_full)) else $error("rx irq wrong");
  AST_TX_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> o_mailbox_tx_empty_irq == !$past(tx_full)) else $error("tx irq wrong");
endmodule

/* dbgmb_link_model.sv */
// Purpose: debugger side of the serial mailbox link
// Assumes: link pins are sampled by the core clock, so changes land on its falling edge
// Notes: link clock stands still between frames; a released data line shows the inverse bit
`timescale 1ns/1ns
module dbgmb_link_model
  import dbgmb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_link_tdo,
  output logic o_link_clk,
  output logic o_link_tdi,
  output logic o_link_shift,
  output logic o_link_update,
  output logic [3:0] o_link_chain
);
  // idle levels; the mailbox sits behind chain 2
  initial begin
    o_link_clk = 1'b0;
    o_link_tdi = 1'b0;
    o_link_shift = 1'b0;
    o_link_update = 1'b0;
    o_link_chain = DBGMB_CHAIN;
  end
  // half a 160 ns link period is eight core cycles
  task automatic half();
    repeat (8) @(negedge i_clk);
  endtask
  task automatic tick();
    o_link_clk = 1'b1;
    half();
    o_link_clk = 1'b0;
    half();
  endtask
  // capture, then 38 shifts lsb first, then update executes the frame
  task automatic frame(input logic wr, input logic [4:0] addr, input logic [31:0] wd, output logic [31:0] q);
    logic [37:0] f;
    f = {wr, addr, wd};
    o_link_shift = 1'b0;
    tick();
    o_link_shift = 1'b1;
    for (int i = 0; i < DBGMB_FRAME; i++) begin
      o_link_tdi = f[i];
      tick();
      // tdo moves on this shift edge, so it is read once the tick is over
      if (i < 32) q[i] = i_link_tdo;
    end
    o_link_shift = 1'b0;
    o_link_tdi = ~o_link_tdi;
    o_link_update = 1'b1;
    half();
    o_link_update = 1'b0;
    half();
  endtask
endmodule

/* test_dbgmb_top.sv */
// Purpose: self-checking bench for the debug mailbox
// Assumes: coprocessor strobes and link frames start on a falling clock edge
// Notes: the link model is driven through its frame task
`timescale 1ns/1ns
module test_dbgmb_top
  import dbgmb_pkg::*;
;
  logic clk = 0, rstn = 0, en = 0, bk = 0, rq = 0, hlt = 0, cmp = 0, irq = 0, fiq = 0, cv = 0, crd = 0;
  logic [3:0] num = DBGMB_CP_NUM, crn = 0, crm = 0;
  logic [2:0] opc = DBGMB_CP_OPC;
  logic [31:0] wd = 0, q, rdata;
  logic v, lclk, ltdi, lsh, lupd, tdo, rvalid, ack, hreq, cirq, cfiq, rxi, txi, scomp;
  logic [3:0] lch;
  int miscompares = 0, checks = 0;
  // 100 MHz core clock
  always #5 clk = ~clk;
  dbgmb_top dbgmb_top_i (.i_clk(clk), .i_rstn(rstn), .i_debug_feature_enable(en), .i_external_breakpoint_in(bk),
    .i_debug_request_in(rq), .i_core_halted(hlt), .i_core_compressed_state(cmp), .i_normal_interrupt_in(irq),
    .i_fast_interrupt_in(fiq), .i_cp_valid(cv), .i_cp_read(crd), .i_cp_num(num), .i_cp_opc(opc), .i_cp_crn(crn),
    .i_cp_crm(crm), .i_cp_wdata(wd), .i_link_clk(lclk), .i_link_tdi(ltdi), .i_link_shift(lsh),
    .i_link_update(lupd), .i_link_chain(lch), .o_link_tdo(tdo), .o_cp_rdata(rdata), .o_cp_rvalid(rvalid),
    .o_debug_acknowledge_out(ack), .o_debug_halt_req(hreq), .o_core_irq(cirq), .o_core_fiq(cfiq),
    .o_mailbox_rx_full_irq(rxi), .o_mailbox_tx_empty_irq(txi), .o_state_compressed(scomp));
  dbgmb_link_model dbgmb_link_model_i (.i_clk(clk), .i_link_tdo(tdo), .o_link_clk(lclk), .o_link_tdi(ltdi),
    .o_link_shift(lsh), .o_link_update(lupd), .o_link_chain(lch));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one coprocessor transfer; the read answer is awaited for three cycles at most
  task automatic cp(input logic rd, input logic [3:0] n, input logic [3:0] r, input logic [31:0] d);
    v = 0;
    q = 0;
    num = n;
    crn = r;
    crd = rd;
    wd = d;
    cv = 1;
    @(negedge clk);
    cv = 0;
    repeat (3) begin
      if (rvalid === 1'b1 && v === 1'b0) begin
        v = 1;
        q = rdata;
      end
      @(negedge clk);
    end
  endtask
  function automatic logic [31:0] ctl(input logic t, input logic r);
    return {DBGMB_VERSION, 26'h0, t, r};
  endfunction
  // tests take about 58 us; a hang ends the run well after that
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    repeat (4) @(negedge clk);
    chk(32'(txi), 32'h1);
    bk = 1;
    rq = 1;
    hlt = 1;
    irq = 1;
    fiq = 1;
    dbgmb_link_model_i.frame(1, DBGMB_ADDR_DATA, 32'h1234_5678, q);
    chk(32'({hreq, ack, cirq, cfiq, rxi}), 32'h6);
    cp(1, DBGMB_CP_NUM, DBGMB_CRN_CTRL, 0);
    chk(q, ctl(0, 0));
    $display("test disabled done");
    hlt = 0;
    @(negedge clk);
    en = 1;
    cmp = 1;
    hlt = 1;
    repeat (6) @(negedge clk);
    chk(32'({hreq, ack, cirq, cfiq, scomp}), 32'h19);
    {bk, rq, hlt, cmp} = 4'h0;
    repeat (6) @(negedge clk);
    hlt = 1;
    repeat (6) @(negedge clk);
    chk(32'({hreq, ack, scomp}), 32'h2);
    hlt = 0;
    $display("test enable done");
    cp(0, 4'hD, DBGMB_CRN_DATA, 32'hDEAD_0001);
    chk(32'(txi), 32'h1);
    cp(0, DBGMB_CP_NUM, DBGMB_CRN_DATA, 32'hA5C3_0F96);
    cp(1, DBGMB_CP_NUM, DBGMB_CRN_CTRL, 0);
    chk(32'(txi), 32'h0);
    chk(q, ctl(1, 0));
    dbgmb_link_model_i.frame(0, DBGMB_ADDR_CTRL, 0, q);
    dbgmb_link_model_i.frame(0, DBGMB_ADDR_CTRL, 0, q);
    chk(q, ctl(1, 0));
    dbgmb_link_model_i.o_link_chain = 4'h3;
    dbgmb_link_model_i.frame(0, DBGMB_ADDR_DATA, 0, q);
    chk(32'(txi), 32'h0);
    dbgmb_link_model_i.o_link_chain = DBGMB_CHAIN;
    dbgmb_link_model_i.frame(0, DBGMB_ADDR_DATA, 0, q);
    chk(32'(txi), 32'h1);
    dbgmb_link_model_i.frame(0, DBGMB_ADDR_DATA, 0, q);
    chk(q, 32'hA5C3_0F96);
    $display("test core to debugger done");
    dbgmb_link_model_i.frame(1, DBGMB_ADDR_DATA, 32'h0BAD_F00D, q);
    chk(32'(rxi), 32'h1);
    cp(1, DBGMB_CP_NUM, DBGMB_CRN_CTRL, 0);
    chk(q, ctl(0, 1));
    crm = 4'h1;
    cp(1, DBGMB_CP_NUM, DBGMB_CRN_DATA, 0);
    chk(32'(v), 32'h0);
    crm = 4'h0;
    cp(1, DBGMB_CP_NUM, DBGMB_CRN_DATA, 0);
    chk(32'(rxi), 32'h0);
    chk(q, 32'h0BAD_F00D);
    dbgmb_link_model_i.frame(1, DBGMB_ADDR_DATA, 32'h5555_AAAA, q);
    chk(32'(rxi), 32'h1);
    dbgmb_link_model_i.frame(1, DBGMB_ADDR_CTRL, 0, q);
    chk(32'(rxi), 32'h0);
    $display("test debugger to core done");
    conclude();
  end
endmodule
